//--- rtl/btx_pkg.sv
// shared constants and types for the bidirectional latch/register transceiver
// assumes one 50 MHz clock and a plain strobe register port
package btx_pkg;

  // ****************************************************
  // widths and timing
  // ****************************************************
  localparam int DATA_W = 18;
  localparam int LOG_DEPTH = 8;
  localparam int ADDR_W = 8;
  localparam int REG_W = 32;
  localparam int CLK_PERIOD_NS = 20;

  // ****************************************************
  // direction indices
  // ****************************************************
  localparam int DIR_AB = 0;
  localparam int DIR_BA = 1;
  localparam int DIR_N = 2;

  // ****************************************************
  // register offsets (byte addresses)
  // ****************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_HELD_AB = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_HELD_BA = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LOG = 8'h10;

  // ****************************************************
  // field positions and reset values
  // ****************************************************
  localparam int CTRL_GUARD_BIT = 0;
  localparam int STAT_CONTEND_BIT = 0;
  localparam int STAT_LOG_NE_BIT = 1;
  localparam int STAT_LOG_FULL_BIT = 2;
  localparam int STAT_OVERFLOW_BIT = 3;
  localparam int LOG_VALID_BIT = 31;
  localparam logic CTRL_GUARD_RESET = 1'b1;
  localparam logic [DATA_W-1:0] HELD_RESET = 18'h00000;
  localparam logic CLK_PREV_RESET = 1'b1;
  localparam logic OE_N_RESET = 1'b1;

  // per-direction control pins
  typedef struct packed {
    logic output_enable;
    logic latch_enable;
    logic capture_clock;
  } btx_dir_ctrl_s;

  // one register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } btx_bus_req_s;

endpackage : btx_pkg

//--- rtl/btx_transceiver.sv
// bidirectional 18-bit latch/register transceiver with capture log
// assumes all pins synchronous to MCLK_IN; the far party avoids contention
//
// Summary of operation
// R01: eighteen bits each way, per-direction controls
// R02: latch enable high passes A to B
// R03: latch enable low, steady clock: hold
// R04: clock rising with latch low captures A
// R05: B driven only while enable high
// R06: enable low floats every B output
// R07: B to A behaves the same way
// R08: B to A enable is active low
// R09: latch falls with clock high: keep level
// R10: latch low, clock low: keep level
// R11: never enable both directions at once; with the CTRL guard bit cleared the code drives both
`timescale 1ns/1ps

// ****************************************************
// fifo used as the capture log
// ****************************************************
module btx_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // handshake flags straight from the fill count
  assign in_ready_out = (count != FULL);
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // pointer and count update
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule : btx_fifo

// ****************************************************
// transceiver top
// ****************************************************
module btx_transceiver #(
  parameter int DATA_W = btx_pkg::DATA_W,
  parameter int LOG_DEPTH = btx_pkg::LOG_DEPTH
) (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  // port A pins
  input wire logic [DATA_W-1:0] A_IN,
  output logic [DATA_W-1:0] A_OUT,
  output logic [DATA_W-1:0] A_OE_N_OUT,
  // port B pins
  input wire logic [DATA_W-1:0] B_IN,
  output logic [DATA_W-1:0] B_OUT,
  output logic [DATA_W-1:0] B_OE_N_OUT,
  // A to B controls
  input wire logic A_TO_B_OUTPUT_ENABLE_IN,
  input wire logic A_TO_B_LATCH_ENABLE_IN,
  input wire logic A_TO_B_CAPTURE_CLOCK_IN,
  // B to A controls
  input wire logic B_TO_A_OUTPUT_ENABLE_N_IN,
  input wire logic B_TO_A_LATCH_ENABLE_IN,
  input wire logic B_TO_A_CAPTURE_CLOCK_IN,
  // register port
  input wire logic [btx_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [btx_pkg::REG_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [btx_pkg::REG_W-1:0] REG_RDATA_OUT,
  // capture log back-pressure
  output logic LOG_READY_OUT
);
  btx_pkg::btx_dir_ctrl_s ctl [btx_pkg::DIR_N];
  btx_pkg::btx_bus_req_s req;
  logic [DATA_W-1:0] src [btx_pkg::DIR_N];
  logic [DATA_W-1:0] held [btx_pkg::DIR_N];
  logic [DATA_W-1:0] next_held [btx_pkg::DIR_N];
  logic clk_prev [btx_pkg::DIR_N];
  logic next_clk_prev [btx_pkg::DIR_N];
  logic capture [btx_pkg::DIR_N];
  logic guard;
  logic next_guard;
  logic contend;
  logic next_contend;
  logic overflow;
  logic next_overflow;
  logic [btx_pkg::REG_W-1:0] rdata;
  logic [btx_pkg::REG_W-1:0] next_rdata;
  logic a_oe_n;
  logic b_oe_n;
  logic next_a_oe_n;
  logic next_b_oe_n;
  logic drive_ab;
  logic drive_ba;
  logic log_valid;
  logic log_pop;
  logic [DATA_W-1:0] log_data;

  // gather pins into per-direction bundles
  assign ctl[btx_pkg::DIR_AB] = '{output_enable: A_TO_B_OUTPUT_ENABLE_IN,
    latch_enable: A_TO_B_LATCH_ENABLE_IN,
    capture_clock: A_TO_B_CAPTURE_CLOCK_IN};
  assign ctl[btx_pkg::DIR_BA] = '{output_enable: ~B_TO_A_OUTPUT_ENABLE_N_IN,
    latch_enable: B_TO_A_LATCH_ENABLE_IN,
    capture_clock: B_TO_A_CAPTURE_CLOCK_IN}; // R08
  assign src[btx_pkg::DIR_AB] = A_IN;
  assign src[btx_pkg::DIR_BA] = B_IN;
  assign req = '{addr: REG_ADDR_IN, wdata: REG_WDATA_IN,
    wr: REG_WR_IN, rd: REG_RD_IN};

  // ****************************************************
  // per-direction storage element
  // ****************************************************
  for (genvar d = 0; d < btx_pkg::DIR_N; d++)
  begin : g_dir
    // transparent, latched or edge-captured next value
    always_comb
    begin
      next_clk_prev[d] = ctl[d].capture_clock;
      capture[d] = ctl[d].capture_clock & ~clk_prev[d]
        & ~ctl[d].latch_enable; // R04
      if (ctl[d].latch_enable)
      begin
        next_held[d] = src[d]; // R02 R07
      end
      else if (capture[d])
      begin
        next_held[d] = src[d]; // R04 R07
      end
      else
      begin
        next_held[d] = held[d]; // R03 R09 R10
      end
    end

    // storage and clock history registers
    always_ff @(posedge MCLK_IN)
    begin
      if (RST_IN)
      begin
        held[d] <= btx_pkg::HELD_RESET;
        clk_prev[d] <= btx_pkg::CLK_PREV_RESET;
      end
      else
      begin
        held[d] <= next_held[d];
        clk_prev[d] <= next_clk_prev[d];
      end
    end
  end

  // ****************************************************
  // output drivers
  // ****************************************************
  // guard keeps A from being driven whenever the A to B enable is high, even if A was driven first
  assign drive_ab = ctl[btx_pkg::DIR_AB].output_enable; // R05 R06
  assign drive_ba = ctl[btx_pkg::DIR_BA].output_enable
    & ~(guard & drive_ab); // R08 R11

  // enables registered so they line up with the stored data
  always_comb
  begin
    next_b_oe_n = ~drive_ab; // R05 R06
    next_a_oe_n = ~drive_ba; // R07 R08
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      a_oe_n <= btx_pkg::OE_N_RESET;
      b_oe_n <= btx_pkg::OE_N_RESET;
    end
    else
    begin
      a_oe_n <= next_a_oe_n;
      b_oe_n <= next_b_oe_n;
    end
  end

  // all bits of a direction share one enable
  assign B_OUT = held[btx_pkg::DIR_AB]; // R01
  assign A_OUT = held[btx_pkg::DIR_BA]; // R01 R07
  assign B_OE_N_OUT = {DATA_W{b_oe_n}}; // R01 R06
  assign A_OE_N_OUT = {DATA_W{a_oe_n}}; // R01 R08

  // ****************************************************
  // capture log of A to B clock edges
  // ****************************************************
  btx_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .in_valid_in(capture[btx_pkg::DIR_AB]),
    .in_ready_out(LOG_READY_OUT),
    .in_data_in(A_IN),
    .out_valid_out(log_valid),
    .out_ready_in(log_pop),
    .out_data_out(log_data)
  );

  // a read of the log register pops one word
  assign log_pop = req.rd & (req.addr == btx_pkg::OFS_LOG);

  // ****************************************************
  // register file
  // ****************************************************
  // control, sticky flags and read data; a new event beats a clear
  always_comb
  begin
    next_guard = guard;
    next_contend = contend;
    next_overflow = overflow;
    next_rdata = '0;
    if (req.wr && req.addr == btx_pkg::OFS_CTRL)
    begin
      next_guard = req.wdata[btx_pkg::CTRL_GUARD_BIT];
    end
    if (req.wr && req.addr == btx_pkg::OFS_STATUS)
    begin
      if (req.wdata[btx_pkg::STAT_CONTEND_BIT])
      begin
        next_contend = 1'b0;
      end
      if (req.wdata[btx_pkg::STAT_OVERFLOW_BIT])
      begin
        next_overflow = 1'b0;
      end
    end
    if (drive_ab && ctl[btx_pkg::DIR_BA].output_enable)
    begin
      next_contend = 1'b1; // R11
    end
    if (capture[btx_pkg::DIR_AB] && !LOG_READY_OUT)
    begin
      next_overflow = 1'b1;
    end
    if (req.rd)
    begin
      unique case (req.addr)
        btx_pkg::OFS_CTRL:
        begin
          next_rdata[btx_pkg::CTRL_GUARD_BIT] = guard;
        end
        btx_pkg::OFS_STATUS:
        begin
          next_rdata[btx_pkg::STAT_CONTEND_BIT] = contend;
          next_rdata[btx_pkg::STAT_LOG_NE_BIT] = log_valid;
          next_rdata[btx_pkg::STAT_LOG_FULL_BIT] = ~LOG_READY_OUT;
          next_rdata[btx_pkg::STAT_OVERFLOW_BIT] = overflow;
        end
        btx_pkg::OFS_HELD_AB:
        begin
          next_rdata[DATA_W-1:0] = held[btx_pkg::DIR_AB];
        end
        btx_pkg::OFS_HELD_BA:
        begin
          next_rdata[DATA_W-1:0] = held[btx_pkg::DIR_BA];
        end
        btx_pkg::OFS_LOG:
        begin
          next_rdata[btx_pkg::LOG_VALID_BIT] = log_valid;
          next_rdata[DATA_W-1:0] = log_valid ? log_data : '0;
        end
        default:
        begin
          next_rdata = '0; // unmapped reads as zero
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      guard <= btx_pkg::CTRL_GUARD_RESET;
      contend <= 1'b0;
      overflow <= 1'b0;
      rdata <= '0;
    end
    else
    begin
      guard <= next_guard;
      contend <= next_contend;
      overflow <= next_overflow;
      rdata <= next_rdata;
    end
  end

  assign REG_RDATA_OUT = rdata;
endmodule : btx_transceiver

//--- dv/btx_far_bus.sv
// far-side bus parties on ports A and B
// assumes one 18-bit wire per port, resolved here for the device inputs
`timescale 1ns/1ps
module btx_far_bus #(
  parameter int W = 18
) (
  // device side
  input wire logic [W-1:0] a_dev_in,
  input wire logic [W-1:0] a_oe_n_in,
  input wire logic [W-1:0] b_dev_in,
  input wire logic [W-1:0] b_oe_n_in,
  // far party wishes
  input wire logic [W-1:0] a_far_in,
  input wire logic [W-1:0] b_far_in,
  // resolved wires
  output logic [W-1:0] a_wire_out,
  output logic [W-1:0] b_wire_out
);
  // ****
  // far party lets go of each bit the device drives
  // ****
  always_comb
  begin
    a_wire_out = (a_dev_in & ~a_oe_n_in) | (a_far_in & a_oe_n_in);
    b_wire_out = (b_dev_in & ~b_oe_n_in) | (b_far_in & b_oe_n_in);
  end
endmodule : btx_far_bus

//--- dv/btx_transceiver_chk.sv
// pin-level checker for the transceiver
// assumes one clock domain and synchronous reset
`timescale 1ns/1ps
module btx_transceiver_chk #(
  parameter int DATA_W = 18,
  parameter int LOG_DEPTH = 8
) (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  // ports
  input wire logic [DATA_W-1:0] A_IN,
  input wire logic [DATA_W-1:0] A_OUT,
  input wire logic [DATA_W-1:0] A_OE_N_OUT,
  input wire logic [DATA_W-1:0] B_IN,
  input wire logic [DATA_W-1:0] B_OUT,
  input wire logic [DATA_W-1:0] B_OE_N_OUT,
  // controls
  input wire logic A_TO_B_OUTPUT_ENABLE_IN,
  input wire logic A_TO_B_LATCH_ENABLE_IN,
  input wire logic A_TO_B_CAPTURE_CLOCK_IN,
  input wire logic B_TO_A_OUTPUT_ENABLE_N_IN,
  input wire logic B_TO_A_LATCH_ENABLE_IN,
  input wire logic B_TO_A_CAPTURE_CLOCK_IN,
  input wire logic LOG_READY_OUT
);
  default clocking dc @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);
  // ****
  // data path
  // ****
  ab_pass_a: assert property (
    A_TO_B_LATCH_ENABLE_IN |=> B_OUT == $past(A_IN))
    else $error("B_OUT missed transparent A");
  ab_capture_a: assert property (
    !A_TO_B_LATCH_ENABLE_IN && $rose(A_TO_B_CAPTURE_CLOCK_IN)
    && !$past(RST_IN) |=> B_OUT == $past(A_IN))
    else $error("B_OUT missed capture");
  ab_hold_a: assert property (
    !A_TO_B_LATCH_ENABLE_IN && !$rose(A_TO_B_CAPTURE_CLOCK_IN)
    && !$past(RST_IN) |=> $stable(B_OUT))
    else $error("B_OUT changed while held");
  ba_pass_a: assert property (
    B_TO_A_LATCH_ENABLE_IN |=> A_OUT == $past(B_IN))
    else $error("A_OUT missed transparent B");
  ba_capture_a: assert property (
    !B_TO_A_LATCH_ENABLE_IN && $rose(B_TO_A_CAPTURE_CLOCK_IN)
    && !$past(RST_IN) |=> A_OUT == $past(B_IN))
    else $error("A_OUT missed capture");
  ba_hold_a: assert property (
    !B_TO_A_LATCH_ENABLE_IN && !$rose(B_TO_A_CAPTURE_CLOCK_IN)
    && !$past(RST_IN) |=> $stable(A_OUT))
    else $error("A_OUT changed while held");
  // ****
  // output enables
  // ****
  ab_drive_a: assert property (
    A_TO_B_OUTPUT_ENABLE_IN |=> B_OE_N_OUT == '0)
    else $error("B not driven");
  ab_float_a: assert property (
    !A_TO_B_OUTPUT_ENABLE_IN |=> &B_OE_N_OUT)
    else $error("B not floating");
  ba_drive_a: assert property (
    !B_TO_A_OUTPUT_ENABLE_N_IN && !A_TO_B_OUTPUT_ENABLE_IN
    |=> A_OE_N_OUT == '0)
    else $error("A not driven");
  ba_float_a: assert property (
    B_TO_A_OUTPUT_ENABLE_N_IN |=> &A_OE_N_OUT)
    else $error("A not floating");
  // main scenarios
  cover property (!A_TO_B_LATCH_ENABLE_IN && $rose(A_TO_B_CAPTURE_CLOCK_IN));
  cover property (!B_TO_A_OUTPUT_ENABLE_N_IN && B_TO_A_LATCH_ENABLE_IN);
  cover property ($fell(LOG_READY_OUT));
  cover property (A_TO_B_OUTPUT_ENABLE_IN && !B_TO_A_OUTPUT_ENABLE_N_IN);
endmodule : btx_transceiver_chk

bind btx_transceiver btx_transceiver_chk #(
  .DATA_W(DATA_W),
  .LOG_DEPTH(LOG_DEPTH)
) i_btx_transceiver_chk (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
  .A_IN(A_IN), .A_OUT(A_OUT), .A_OE_N_OUT(A_OE_N_OUT),
  .B_IN(B_IN), .B_OUT(B_OUT), .B_OE_N_OUT(B_OE_N_OUT),
  .A_TO_B_OUTPUT_ENABLE_IN(A_TO_B_OUTPUT_ENABLE_IN),
  .A_TO_B_LATCH_ENABLE_IN(A_TO_B_LATCH_ENABLE_IN),
  .A_TO_B_CAPTURE_CLOCK_IN(A_TO_B_CAPTURE_CLOCK_IN),
  .B_TO_A_OUTPUT_ENABLE_N_IN(B_TO_A_OUTPUT_ENABLE_N_IN),
  .B_TO_A_LATCH_ENABLE_IN(B_TO_A_LATCH_ENABLE_IN),
  .B_TO_A_CAPTURE_CLOCK_IN(B_TO_A_CAPTURE_CLOCK_IN),
  .LOG_READY_OUT(LOG_READY_OUT)
);

//--- dv/testbench.sv
// self-checking bench for the transceiver
// assumes the far-bus model and the bound checker
`timescale 1ns/1ps
module testbench;
  localparam int W = btx_pkg::DATA_W;
  logic clk = 0;
  logic rst = 1;
  logic oe_ab = 0, le_ab = 0, ck_ab = 0;
  logic oe_ba_n = 1, le_ba = 0, ck_ba = 0;
  logic [W-1:0] a_drv = '0, b_drv = '0, a_w, b_w, v;
  logic [W-1:0] a_out, a_oe_n, b_out, b_oe_n;
  logic [7:0] addr = '0;
  logic [31:0] wd = '0, rdata;
  logic wr = 0, rd = 0, log_rdy;
  int err_count = 0, n_tests = 0, seed = 64;
  logic [W-1:0] q[$];

  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  btx_transceiver i_btx_transceiver (
    .MCLK_IN(clk), .RST_IN(rst),
    .A_IN(a_w), .A_OUT(a_out), .A_OE_N_OUT(a_oe_n),
    .B_IN(b_w), .B_OUT(b_out), .B_OE_N_OUT(b_oe_n),
    .A_TO_B_OUTPUT_ENABLE_IN(oe_ab), .A_TO_B_LATCH_ENABLE_IN(le_ab),
    .A_TO_B_CAPTURE_CLOCK_IN(ck_ab),
    .B_TO_A_OUTPUT_ENABLE_N_IN(oe_ba_n), .B_TO_A_LATCH_ENABLE_IN(le_ba),
    .B_TO_A_CAPTURE_CLOCK_IN(ck_ba),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .LOG_READY_OUT(log_rdy)
  );

  btx_far_bus #(.W(W)) i_btx_far_bus (
    .a_dev_in(a_out), .a_oe_n_in(a_oe_n),
    .b_dev_in(b_out), .b_oe_n_in(b_oe_n),
    .a_far_in(a_drv), .b_far_in(b_drv),
    .a_wire_out(a_w), .b_wire_out(b_w)
  );

  // ****
  // helpers
  // ****
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one read; data stands only in the following cycle
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1;
    tick(1);
    chk(rdata, e);
    rd <= 0;
    tick(1);
  endtask : rd_chk

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wd <= d;
    wr <= 1;
    tick(1);
    wr <= 0;
    tick(1);
  endtask : wr_reg

  // one low-then-high capture clock cycle with latch closed
  task cap_ab(input logic [W-1:0] d);
    a_drv <= d;
    ck_ab <= 0;
    tick(1);
    ck_ab <= 1;
    tick(1);
    chk(b_out, d);
  endtask : cap_ab

  task summarize;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // watchdog well beyond the expected 130 or so cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    summarize();
  end

  // ****
  // scenarios
  // ****
  initial
  begin
    tick(16);
    rst <= 0;
    tick(1);
    chk(b_oe_n, 32'h3ffff);
    chk(log_rdy, 32'h1);
    rd_chk(8'h00, 32'h1);
    rd_chk(8'h20, 32'h0);
    $display("test reset done");
    oe_ab <= 1;
    le_ab <= 1;
    for (int i = 0; i < 20; i++)
    begin
      v = (i == 0) ? '1 : W'($random(seed));
      a_drv <= v;
      ck_ab <= 1'($random(seed));
      tick(1);
      chk(b_out, v);
      chk(b_oe_n, 32'h0);
    end
    $display("test transparent done");
    le_ab <= 0;
    cap_ab(18'h2aaaa);
    for (int k = 1; k >= 0; k--)
    begin
      ck_ab <= k[0];
      repeat (3)
      begin
        a_drv <= W'($random(seed));
        tick(1);
        chk(b_out, 32'h2aaaa);
      end
    end
    ck_ab <= 1;
    le_ab <= 1;
    a_drv <= 18'h15555;
    tick(1);
    le_ab <= 0;
    a_drv <= 18'h0f0f0;
    tick(3);
    chk(b_out, 32'h15555);
    rd_chk(8'h08, 32'h15555);
    oe_ab <= 0;
    tick(1);
    chk(b_oe_n, 32'h3ffff);
    $display("test latch done");
    oe_ba_n <= 0;
    le_ba <= 1;
    repeat (10)
    begin
      v = W'($random(seed));
      b_drv <= v;
      tick(1);
      chk(a_out, v);
      chk(a_oe_n, 32'h0);
    end
    // B to A latched, then captured on a rising edge, then held
    le_ba <= 0;
    b_drv <= 18'h1c3c3;
    tick(1);
    chk(a_out, v);
    ck_ba <= 1;
    tick(1);
    chk(a_out, 32'h1c3c3);
    b_drv <= W'($random(seed));
    tick(2);
    chk(a_out, 32'h1c3c3);
    rd_chk(8'h0c, 32'h1c3c3);
    // both directions requested on purpose: guard keeps A floating
    oe_ab <= 1;
    tick(1);
    chk(a_oe_n, 32'h3ffff);
    chk(b_oe_n, 32'h0);
    oe_ab <= 0;
    rd_chk(8'h04, 32'h3);
    wr_reg(8'h04, 32'h1);
    rd_chk(8'h04, 32'h2);
    // guard off: the B to A enable is obeyed again
    wr_reg(8'h00, 32'h0);
    rd_chk(8'h00, 32'h0);
    oe_ab <= 1;
    tick(1);
    chk(a_oe_n, 32'h0);
    oe_ab <= 0;
    oe_ba_n <= 1;
    tick(1);
    chk(a_oe_n, 32'h3ffff);
    $display("test b to a done");
    rst <= 1;
    oe_ab <= 1;
    tick(2);
    rst <= 0;
    tick(1);
    for (int i = 0; i < 9; i++)
    begin
      v = W'($random(seed));
      cap_ab(v);
      if (i < 8)
        q.push_back(v);
      if (i == 7)
        chk(log_rdy, 32'h0);
    end
    rd_chk(8'h04, 32'he);
    while (q.size() > 0)
      rd_chk(8'h10, 32'h80000000 | q.pop_front());
    rd_chk(8'h04, 32'h8);
    wr_reg(8'h04, 32'h8);
    rd_chk(8'h04, 32'h0);
    chk(log_rdy, 32'h1);
    $display("test log done");
    summarize();
  end
endmodule : testbench
